// >>> hw/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
// Overview of operation
// - Each conversion takes ten setup ticks, then four ticks per result bit.
// - At completion, load both result registers, set done status and interrupt flag.
// - The done status reads zero while a conversion runs.
// - The twelve-bit result is found bit by bit by successive approximation.
// - The four-bit channel field picks the analog input for each conversion.
// - The three-bit trigger field picks software start or one of five timer events.
// - Alignment zero puts bits 11:4 high and bits 3:0 in the low upper nibble.
// - Alignment one puts bits 11:8 in the high low nibble, bits 7:0 low.
// - The conversion clock is the system clock divided by one, two, four or eight.

// Register indices; the byte address is four times the index.
`define SAC_IDX_CTRL_LO 10'h09C
`define SAC_IDX_CTRL_HI 10'h09D
`define SAC_IDX_RES_LO  10'h09E
`define SAC_IDX_RES_HI  10'h09F
`define SAC_IDX_STAT    10'h0A0
`define SAC_IDX_MASK    10'h0A1
// Field positions.
`define SAC_LO_EN       7
`define SAC_LO_START    6
`define SAC_LO_REF      5
`define SAC_LO_DONE     4
`define SAC_LO_CHAN     3:0
`define SAC_HI_IRQF     7
`define SAC_HI_TRIGGER_SOURCE_SELECT     5:3
`define SAC_HI_ALIGN    2
`define SAC_HI_CONV_CLOCK_DIVIDER_SELECT    1:0
`define SAC_ST_DONE     0
// Result slices.
`define SAC_R_HI8       11:4
`define SAC_R_LO4       3:0
`define SAC_R_HI4       11:8
`define SAC_R_LO8       7:0
// Timing counts in conversion ticks, and the index of the first result bit.
`define SAC_SETUP_LAST  6'd9
`define SAC_BIT_LAST    6'd3
`define SAC_CONV_TICKS  6'd58
`define SAC_MSB         4'd11
// Trigger codes.
`define SAC_TRIGGER_SOURCE_SELECT_SW     3'h0
`define SAC_TRIGGER_SOURCE_SELECT_LAST   3'h5
`endif

// >>> hw/sac_pkg.sv
package sac_pkg;
   typedef enum logic [1:0] {
      sac_idle  = 2'b00,
      sac_setup = 2'b01,
      sac_bits  = 2'b11
   } sac_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [9:0] idx;
   } sac_aphase_t;

   typedef struct packed {
      logic       en;
      logic       reference_select;
      logic [3:0] chan;
      logic [2:0] trigger_source_select;
      logic       align;
      logic [1:0] conv_clock_divider_select;
   } sac_ctrl_t;
endpackage : sac_pkg

// >>> hw/sac_top.sv
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_top (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Timer events: 0 t1 A, 1 t4 ovf, 2 t4 A, 3 t4 B, 4 t4 C.
   input  wire logic [4:0]  timer_evt,
   input  wire logic        stop_mode,
   // Analog front end.
   input  wire logic        comp_in,
   output logic      [11:0] dac_code,
   output logic      [3:0]  mux_sel,
   output logic             conv_enable,
   output logic             ref_ext,
   // Interrupt.
   output logic             irq
);

   sac_pkg::sac_state_t  state_r;
   sac_pkg::sac_aphase_t ap_r;
   sac_pkg::sac_ctrl_t   ctrl_r;
   logic        comp_m_r;
   logic        comp_q_r;
   logic [2:0]  div_r;
   logic [5:0]  cnt_r;
   logic [3:0]  bit_r;
   logic [11:0] sar_r;
   logic [11:0] sar_nxt;
   logic [7:0]  res_hi_r;
   logic [7:0]  res_lo_r;
   logic        done_st_r;
   logic        irqf_r;
   logic        stat_r;
   logic        mask_r;
   logic [31:0] rd_nxt;
   logic [5:0]  tick_tot_r;
   logic        acc;
   logic        wr_lo;
   logic        wr_hi;
   logic        sw_start;
   logic        go;
   logic        active;
   logic        start;
   logic        tick;
   logic        done_evt;
   logic        en_now;
   logic [3:0]  chan_now;

   // Address decode shared by reads and writes.
   function automatic logic is_reg(input logic [9:0] idx, input logic [9:0] target);
      is_reg = (idx == target);
   endfunction : is_reg

   // Low bits of the divider that must all be set for one conversion tick.
   function automatic logic [2:0] dmask(input logic [1:0] sel);
      dmask = 3'((4'h1 << sel) - 4'h1);
   endfunction : dmask

   // One-hot weight of a result bit.
   function automatic logic [11:0] bmask(input logic [3:0] i);
      bmask = 12'(16'h1 << i);
   endfunction : bmask

   // The comparator is asynchronous to clk, so it passes two flip-flops.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         comp_m_r <= 1'b0;
         comp_q_r <= 1'b0;
      end else begin
         comp_m_r <= comp_in;
         comp_q_r <= comp_m_r;
      end
   end

   // Bus strobes; only whole-word single transfers are expected.
   assign acc      = hsel & hready & htrans[1];
   assign wr_lo    = ap_r.wr & is_reg(ap_r.idx, `SAC_IDX_CTRL_LO);
   assign wr_hi    = ap_r.wr & is_reg(ap_r.idx, `SAC_IDX_CTRL_HI);
   assign sw_start = wr_lo & hwdata[`SAC_LO_START];
   // A write in flight counts at once, so one write may enable, pick a channel and start.
   assign en_now   = wr_lo ? hwdata[`SAC_LO_EN] : ctrl_r.en;
   assign chan_now = wr_lo ? hwdata[`SAC_LO_CHAN] : ctrl_r.chan;
   assign active   = en_now & ~stop_mode;
   assign start    = go & active & (state_r == sac_pkg::sac_idle);
   assign tick     = ((div_r & dmask(ctrl_r.conv_clock_divider_select)) == dmask(ctrl_r.conv_clock_divider_select));
   assign done_evt = active & tick & (state_r == sac_pkg::sac_bits)
                     & (cnt_r == `SAC_BIT_LAST) & (bit_r == 4'h0);

   // Trigger source selection; unused codes never start a conversion.
   always_comb begin
      go = 1'b0;
      if (ctrl_r.trigger_source_select == `SAC_TRIGGER_SOURCE_SELECT_SW) begin
         go = sw_start;
      end else if (ctrl_r.trigger_source_select <= `SAC_TRIGGER_SOURCE_SELECT_LAST) begin
         go = timer_evt[ctrl_r.trigger_source_select - 3'h1];
      end
   end

   // Capture the address phase; the slave never inserts wait states.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ap_r <= '0;
      end else begin
         ap_r.wr  <= acc & hwrite;
         ap_r.rd  <= acc & ~hwrite;
         ap_r.idx <= haddr[11:2];
      end
   end

   // Control fields; the start bit is a strobe and is never stored.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_r <= '0;
      end else begin
         if (wr_lo) begin
            ctrl_r.en     <= hwdata[`SAC_LO_EN];
            ctrl_r.reference_select <= hwdata[`SAC_LO_REF];
            ctrl_r.chan   <= hwdata[`SAC_LO_CHAN];
         end
         if (wr_hi) begin
            ctrl_r.trigger_source_select   <= hwdata[`SAC_HI_TRIGGER_SOURCE_SELECT];
            ctrl_r.align  <= hwdata[`SAC_HI_ALIGN];
            ctrl_r.conv_clock_divider_select  <= hwdata[`SAC_HI_CONV_CLOCK_DIVIDER_SELECT];
         end
      end
   end

   // Divider restarts at each start so the first tick is at a known place.
   always_ff @(posedge clk) begin
      if (!rstn || start) begin
         div_r <= 3'h0;
      end else begin
         div_r <= div_r + 3'h1;
      end
   end

   // Decide the current bit and pose the next trial.
   always_comb begin
      sar_nxt = comp_q_r ? sar_r : (sar_r & ~bmask(bit_r));
      if (bit_r != 4'h0) begin
         sar_nxt = sar_nxt | bmask(bit_r - 4'h1);
      end
   end

   // Conversion sequencer; losing the enable aborts at once.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_r <= sac_pkg::sac_idle;
         cnt_r   <= 6'h00;
         bit_r   <= 4'h0;
         sar_r   <= 12'h000;
      end else if (!active) begin
         state_r <= sac_pkg::sac_idle;
      end else begin
         case (state_r)
            sac_pkg::sac_idle: begin
               if (start) begin
                  state_r <= sac_pkg::sac_setup;
                  cnt_r   <= 6'h00;
                  sar_r   <= 12'h000;
               end
            end
            sac_pkg::sac_setup: begin
               if (tick && cnt_r == `SAC_SETUP_LAST) begin
                  state_r <= sac_pkg::sac_bits;
                  cnt_r   <= 6'h00;
                  bit_r   <= `SAC_MSB;
                  sar_r   <= bmask(`SAC_MSB);
               end else if (tick) begin
                  cnt_r <= cnt_r + 6'h01;
               end
            end
            sac_pkg::sac_bits: begin
               if (tick && cnt_r == `SAC_BIT_LAST) begin
                  cnt_r <= 6'h00;
                  sar_r <= sar_nxt;
                  if (bit_r == 4'h0) begin
                     state_r <= sac_pkg::sac_idle;
                  end else begin
                     bit_r <= bit_r - 4'h1;
                  end
               end else if (tick) begin
                  cnt_r <= cnt_r + 6'h01;
               end
            end
            default: begin
               state_r <= sac_pkg::sac_idle;
            end
         endcase
      end
   end

   // Result alignment at completion.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         res_hi_r <= 8'h00;
         res_lo_r <= 8'h00;
      end else if (done_evt && !ctrl_r.align) begin
         res_hi_r <= sar_nxt[`SAC_R_HI8];
         res_lo_r <= {sar_nxt[`SAC_R_LO4], 4'h0};
      end else if (done_evt) begin
         res_hi_r <= {4'h0, sar_nxt[`SAC_R_HI4]};
         res_lo_r <= sar_nxt[`SAC_R_LO8];
      end
   end

   // Done status: cleared by each start and by stop mode.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         done_st_r <= 1'b0;
      end else if (done_evt) begin
         done_st_r <= 1'b1;
      end else if (start || stop_mode) begin
         done_st_r <= 1'b0;
      end
   end

   // Flag in the control register: writing zero clears, a new event wins.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqf_r <= 1'b0;
      end else if (done_evt) begin
         irqf_r <= 1'b1;
      end else if (wr_hi && !hwdata[`SAC_HI_IRQF]) begin
         irqf_r <= 1'b0;
      end
   end

   // Sticky status, cleared by a read unless an event lands together.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         stat_r <= 1'b0;
      end else if (done_evt) begin
         stat_r <= 1'b1;
      end else if (acc && !hwrite && is_reg(haddr[11:2], `SAC_IDX_STAT)) begin
         stat_r <= 1'b0;
      end
   end

   // Interrupt mask.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_r <= 1'b0;
      end else if (ap_r.wr && is_reg(ap_r.idx, `SAC_IDX_MASK)) begin
         mask_r <= hwdata[`SAC_ST_DONE];
      end
   end

   // Read mux; unmapped words read as zero.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (haddr[11:2])
         `SAC_IDX_CTRL_LO: begin
            rd_nxt[`SAC_LO_EN]   = ctrl_r.en;
            rd_nxt[`SAC_LO_REF]  = ctrl_r.reference_select;
            rd_nxt[`SAC_LO_DONE] = done_st_r;
            rd_nxt[`SAC_LO_CHAN] = ctrl_r.chan;
         end
         `SAC_IDX_CTRL_HI: begin
            rd_nxt[`SAC_HI_IRQF]  = irqf_r;
            rd_nxt[`SAC_HI_TRIGGER_SOURCE_SELECT]  = ctrl_r.trigger_source_select;
            rd_nxt[`SAC_HI_ALIGN] = ctrl_r.align;
            rd_nxt[`SAC_HI_CONV_CLOCK_DIVIDER_SELECT] = ctrl_r.conv_clock_divider_select;
         end
         `SAC_IDX_RES_LO: rd_nxt[7:0] = res_lo_r;
         `SAC_IDX_RES_HI: rd_nxt[7:0] = res_hi_r;
         `SAC_IDX_STAT:   rd_nxt[`SAC_ST_DONE] = stat_r;
         `SAC_IDX_MASK:   rd_nxt[`SAC_ST_DONE] = mask_r;
         default:         rd_nxt = 32'h0000_0000;
      endcase
   end

   // Read data is latched at the end of the address phase for the data phase.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (acc && !hwrite) begin
            hrdata <= rd_nxt;
         end
      end
   end

   // Analog side outputs; the channel is held for the whole conversion.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mux_sel     <= 4'h0;
         dac_code    <= 12'h000;
         conv_enable <= 1'b0;
         ref_ext     <= 1'b0;
         irq         <= 1'b0;
      end else begin
         if (start) begin
            mux_sel <= chan_now;
         end
         dac_code    <= sar_r;
         conv_enable <= active;
         ref_ext     <= ctrl_r.reference_select;
         irq         <= (stat_r | done_evt) & mask_r;
      end
   end

   // Tick total since start, read only by the checks below.
   always_ff @(posedge clk) begin
      if (!rstn || start) begin
         tick_tot_r <= 6'h00;
      end else if (tick && state_r != sac_pkg::sac_idle) begin
         tick_tot_r <= tick_tot_r + 6'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_loaded;
      ##1 done_st_r && irqf_r && stat_r;
   endsequence

   sequence s_stop_off;
      ##1 state_r == sac_pkg::sac_idle ##1 !conv_enable;
   endsequence

   a_conv_length: assert property (done_evt |-> tick_tot_r == `SAC_CONV_TICKS - 6'h01)
      else $error("Conversion did not take 58 ticks.");
   a_done_load: assert property (done_evt |-> s_loaded)
      else $error("Completion did not set done and interrupt flags.");
   a_busy_reads0: assert property (state_r != sac_pkg::sac_idle && acc && !hwrite
      && is_reg(haddr[11:2], `SAC_IDX_CTRL_LO) |=> !hrdata[`SAC_LO_DONE])
      else $error("Done status read as one during conversion.");
   a_sar_drop: assert property (state_r == sac_pkg::sac_bits && tick && active
      && cnt_r == `SAC_BIT_LAST && !comp_q_r |=> (sar_r & $past(bmask(bit_r))) == 12'h000)
      else $error("Trial bit kept although comparator was low.");
   a_chan_route: assert property (start |=> mux_sel == $past(chan_now))
      else $error("Channel not routed at start.");
   a_timer_start: assert property (active && state_r == sac_pkg::sac_idle
      && ctrl_r.trigger_source_select == 3'h1 && timer_evt[0] |=> state_r == sac_pkg::sac_setup)
      else $error("Timer event did not start a conversion.");
   a_align_msb: assert property (done_evt && !ctrl_r.align |=> res_hi_r == $past(sar_nxt[11:4])
      && res_lo_r[3:0] == 4'h0)
      else $error("Left-aligned result misplaced.");
   a_align_lsb: assert property (done_evt && ctrl_r.align |=> res_lo_r == $past(sar_nxt[7:0])
      && res_hi_r[7:4] == 4'h0)
      else $error("Right-aligned result misplaced.");
   a_div_eight: assert property (tick && ctrl_r.conv_clock_divider_select == 2'h3 && !start
      |=> (!tick || ctrl_r.conv_clock_divider_select != 2'h3) [*7])
      else $error("Divide-by-eight ticked early.");
   a_stop_off: assert property (stop_mode && $stable(stop_mode) |-> ##0 s_stop_off or
      ##1 !stop_mode)
      else $error("Converter stayed enabled in stop mode.");
   a_sw_start: assert property (sw_start && ctrl_r.trigger_source_select == 3'h0 && active
      && state_r == sac_pkg::sac_idle |=> state_r == sac_pkg::sac_setup
      && !hrdata[`SAC_LO_START])
      else $error("Software start did not begin a conversion.");
endmodule : sac_top

// >>> sim/sac_front_model.sv
`timescale 1ns/1ps
module sac_front_model (
   // Clock.
   input  wire logic        clk,
   // Converter side.
   input  wire logic        conv_enable,
   input  wire logic [3:0]  mux_sel,
   input  wire logic [11:0] dac_code,
   output logic             comp_in
);
   logic [11:0] vin;
   logic        junk = 1'b0;

   // Each channel carries its own fixed level, so a wrong channel gives a wrong code.
   assign vin = {mux_sel, ~mux_sel, mux_sel};

   // An idle comparator output is noise, never a stale decision.
   always_ff @(posedge clk) begin
      junk <= ~junk;
   end

   // Keep-bit answer while powered; the answer is unclocked like the real comparator.
   assign comp_in = conv_enable ? (vin >= dac_code) : junk;
endmodule : sac_front_model

// >>> sim/sar_adc_control_bench.sv
`timescale 1ns/1ps
module sar_adc_control_bench;
   localparam logic [31:0] A_CL = 32'h0000_0270;
   localparam logic [31:0] A_CH = 32'h0000_0274;
   localparam logic [31:0] A_RL = 32'h0000_0278;
   localparam logic [31:0] A_RH = 32'h0000_027C;
   localparam logic [31:0] A_ST = 32'h0000_0280;
   localparam logic [31:0] A_MK = 32'h0000_0284;
   localparam logic [31:0] A_NO = 32'h0000_0300;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [4:0]  timer_evt = 5'h00;
   logic        stop_mode = 1'b0;
   logic        comp_in;
   logic [11:0] dac_code;
   logic [3:0]  mux_sel;
   logic        conv_enable;
   logic        ref_ext;
   logic        irq;
   int          failures = 0;
   int          checks = 0;

   // The single slave's ready is the bus ready.
   assign hready = hreadyout;

   // System clock at 10 MHz.
   always #50 clk = ~clk;

   sac_top i_dut (
      .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_evt(timer_evt), .stop_mode(stop_mode), .comp_in(comp_in),
      .dac_code(dac_code), .mux_sel(mux_sel), .conv_enable(conv_enable),
      .ref_ext(ref_ext), .irq(irq)
   );

   sac_front_model i_front (
      .clk(clk), .conv_enable(conv_enable), .mux_sel(mux_sel),
      .dac_code(dac_code), .comp_in(comp_in)
   );

   task automatic close_out;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   // A wait that runs out is a mismatch and ends the run.
   task automatic tmo;
      failures++;
      $display("BAD wait expected done seen timeout");
      close_out();
   endtask : tmo

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Hold each phase until ready is sampled high at a rising edge.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      int n;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) tmo();
      htrans <= 2'b00;
      hwdata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) tmo();
      r = hrdata;
   endtask : xfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic wait_irq(input int lim, output int n);
      n = 0;
      while (irq !== 1'b1) begin
         @(posedge clk);
         n++;
         if (n > lim) tmo();
      end
   endtask : wait_irq

   // Level each channel presents, worked out independently of the model.
   function automatic logic [11:0] lvl(input logic [3:0] ch);
      return {ch, ~ch, ch};
   endfunction : lvl

   task automatic t_reset;
      logic [31:0] r;
      xfer(1'b0, A_CL, 32'h0, r);
      chk("ctrl low reset", 32'h0, r);
      xfer(1'b0, A_CH, 32'h0, r);
      chk("ctrl high reset", 32'h0, r);
      xfer(1'b0, A_NO, 32'h0, r);
      chk("unmapped read", 32'h0, r);
      chk("response", 32'h0, {31'h0, hresp});
      $display("test reset done");
   endtask : t_reset

   // Divide codes 2 and 3 keep the conversion above twenty microseconds.
   task automatic t_sw(input logic [3:0] ch, input logic [1:0] ck, input logic al);
      logic [31:0] r;
      logic [11:0] v;
      int          n;
      int          t;
      v = lvl(ch);
      t = 58 << ck;
      wr(A_CH, {24'h0, 2'b00, 3'h0, al, ck});
      wr(A_MK, 32'h1);
      wr(A_CL, {24'h0, 4'hC, ch});
      xfer(1'b0, A_CL, 32'h0, r);
      chk("busy ctrl low", {24'h0, 4'h8, ch}, r);
      chk("channel", {28'h0, ch}, {28'h0, mux_sel});
      wait_irq(t + 40, n);
      chk("conv time", 32'h1, {31'h0, (n + 2 >= t - 2) && (n + 2 <= t + 4)});
      xfer(1'b0, A_RH, 32'h0, r);
      chk("result high", al ? {28'h0, v[11:8]} : {24'h0, v[11:4]}, r);
      xfer(1'b0, A_RL, 32'h0, r);
      chk("result low", al ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0}, r);
      xfer(1'b0, A_CL, 32'h0, r);
      chk("done ctrl low", {24'h0, 4'h9, ch}, r);
      xfer(1'b0, A_CH, 32'h0, r);
      chk("irq flag", {24'h0, 2'b10, 3'h0, al, ck}, r);
      xfer(1'b0, A_ST, 32'h0, r);
      chk("status", 32'h1, r);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test software start done");
   endtask : t_sw

   // Trigger codes one to six, with every other event pulsed first to prove it is ignored.
   task automatic t_trigger_source_select;
      logic [31:0] r;
      int          n;
      for (int c = 1; c <= 6; c++) begin
         wr(A_CH, {24'h0, 2'b00, c[2:0], 3'b010});
         timer_evt <= 5'h1F ^ (5'h01 << (c - 1));
         @(posedge clk);
         timer_evt <= 5'h00;
         repeat (260) @(posedge clk);
         xfer(1'b0, A_ST, 32'h0, r);
         chk("foreign trigger", 32'h0, r);
         if (c < 6) begin
            timer_evt <= 5'h01 << (c - 1);
            @(posedge clk);
            timer_evt <= 5'h00;
            wait_irq(300, n);
            xfer(1'b0, A_ST, 32'h0, r);
            chk("own trigger", 32'h1, r);
         end
      end
      $display("test triggers done");
   endtask : t_trigger_source_select

   task automatic t_mask;
      logic [31:0] r;
      wr(A_CH, 32'h0000_0002);
      wr(A_MK, 32'h0);
      wr(A_CL, 32'h0000_00E5);
      repeat (260) @(posedge clk);
      chk("masked irq", 32'h0, {31'h0, irq});
      chk("reference", 32'h1, {31'h0, ref_ext});
      wr(A_MK, 32'h1);
      repeat (2) @(posedge clk);
      chk("unmasked irq", 32'h1, {31'h0, irq});
      xfer(1'b0, A_ST, 32'h0, r);
      repeat (3) @(posedge clk);
      chk("irq after read", 32'h0, {31'h0, irq});
      $display("test mask done");
   endtask : t_mask

   // Stop mode must abort a running conversion, and a start written with the enable cleared must not begin one.
   task automatic t_stop;
      logic [31:0] r;
      wr(A_CL, 32'h0000_00C1);
      repeat (20) @(posedge clk);
      stop_mode <= 1'b1;
      repeat (3) @(posedge clk);
      chk("stop power", 32'h0, {31'h0, conv_enable});
      stop_mode <= 1'b0;
      repeat (260) @(posedge clk);
      xfer(1'b0, A_ST, 32'h0, r);
      chk("stop status", 32'h0, r);
      wr(A_CL, 32'h0000_0041);
      repeat (3) @(posedge clk);
      chk("off power", 32'h0, {31'h0, conv_enable});
      repeat (260) @(posedge clk);
      xfer(1'b0, A_ST, 32'h0, r);
      chk("off status", 32'h0, r);
      $display("test stop done");
   endtask : t_stop

   // Main sequence.
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_sw(4'h3, 2'b10, 1'b0);
      t_sw(4'hA, 2'b11, 1'b1);
      t_trigger_source_select();
      t_mask();
      t_stop();
      close_out();
   end
endmodule : sar_adc_control_bench
